// *** include/txr_pkg.sv ***
package txr_pkg;
	// frame layout
	localparam int FRAME_BITS = 24;
	localparam int ADDR_BITS = 4;
	localparam int DATA_BITS = 20;
	localparam int REG_COUNT = 8;
	// register addresses
	localparam logic [3:0] ADDR_RF_MAIN = 4'h0;
	localparam logic [3:0] ADDR_RF_REF = 4'h1;
	localparam logic [3:0] ADDR_IF_MAIN = 4'h2;
	localparam logic [3:0] ADDR_IF_REF = 4'h3;
	localparam logic [3:0] ADDR_OPCTL = 4'h4;
	localparam logic [3:0] ADDR_SETUP = 4'h5;
	localparam logic [3:0] ADDR_BIAS = 4'h6;
	localparam logic [3:0] ADDR_TEST = 4'h7;
	localparam int ADDR_TOP = 3;
	// widths
	localparam int W_RF_MAIN = 18;
	localparam int W_RF_REF = 13;
	localparam int W_IF_MAIN = 14;
	localparam int W_IF_REF = 11;
	localparam int W_CTL = 16;
	localparam int W_TEST = 9;
	// operation_control fields
	localparam int OP_RF_BOOST_HI = 14;
	localparam int OP_IF_FORCE = 13;
	localparam int OP_GAIN_HI = 8;
	localparam int OP_GAIN_LO = 6;
	localparam int OP_LO_BUF = 4;
	localparam int OP_MOD_SEL = 3;
	localparam int OP_STANDBY = 2;
	localparam int OP_TX_STANDBY = 1;
	localparam int OP_POWER_OFF = 0;
	// setup_register fields
	localparam int SU_IF_SYNTH = 15;
	localparam int SU_RF_SYNTH = 14;
	localparam int SU_BB_LEVEL = 12;
	localparam int SU_IFCP_HI = 9;
	localparam int SU_IFCP_LO = 8;
	localparam int SU_RFCP_HI = 7;
	localparam int SU_RFCP_LO = 6;
	localparam int SU_IF_TURBO = 3;
	localparam int SU_RF_BOOST_LO = 2;
	localparam int SU_LOCK_HI = 1;
	localparam int SU_LOCK_LO = 0;
	// bias_current_control fields
	localparam int BI_MAX_POWER = 11;
	localparam int BI_THR_HI = 6;
	localparam int BI_THR_LO = 4;
	localparam int BI_SCALE_HI = 3;
	localparam int BI_SCALE_LO = 0;
	// lock indicator select codes
	localparam logic [1:0] LOCK_TEST = 2'h0;
	localparam logic [1:0] LOCK_IF = 2'h1;
	localparam logic [1:0] LOCK_RF = 2'h2;
	localparam logic [1:0] LOCK_BOTH = 2'h3;
	// rf boost modes (hi,lo)
	localparam logic [1:0] BOOST_NONE = 2'h0;
	localparam logic [1:0] BOOST_PROG = 2'h1;
	localparam logic [1:0] BOOST_ALWAYS = 2'h2;
	localparam logic [1:0] BOOST_UNLOCK = 2'h3;
	// serial pins, carried together
	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic sdata;
	} txr_serial_t;
	// section enables driven out to the analog blocks
	typedef struct packed {
		logic upconverter_on;
		logic modulator_on;
		logic if_osc_on;
		logic if_synth_on;
		logic rf_synth_on;
		logic lo_buffer_on;
		logic bias_on;
	} txr_power_t;
endpackage : txr_pkg

// *** src/txr_reg_mem.sv ***
`timescale 1ns/1ps
// eight write-only control words, 18 bits each; read port is registered
module txr_reg_mem (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// write port
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [17:0] wr_data,
	// flat registered view of all words
	output logic [8*18-1:0] rd_all
);
	logic [17:0] mem [8];
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_word
			// contents kept across every shutdown mode; only nrst clears
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					mem[gi] <= 18'h0;
				end else if (wr_en && wr_idx == 3'(gi)) begin
					mem[gi] <= wr_data;
				end
			end
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					rd_all[gi*18 +: 18] <= 18'h0;
				end else begin
					rd_all[gi*18 +: 18] <= mem[gi];
				end
			end
		end
	endgenerate
endmodule : txr_reg_mem

// *** src/txr_serial_regs.sv ***
`timescale 1ns/1ps
//
// Behaviour
// - four divider counts decoded at addresses 0..3, widths 18/13/14/11
// - operation bit 13 holds IF pump at turbo level, even after lock
// - operation bits 8:6 give three-bit IF gain trim code
// - operation bit 3 selects direct oscillator (0) or quadrature (1) modulation
// - operation bit 2 low powers down all but registers and serial port
// - operation bit 1 low disables modulator and upconverter, like gate pin
// - operation bit 0 low powers down everything except registers and serial port
// - setup bits 15 and 14 low shut down IF and RF synthesizers
// - setup bit 12 selects baseband level, 0 small, 1 large
// - setup bits 9:8 select IF charge-pump current
// - setup bits 7:6 select RF charge-pump current
// - setup bit 3 enables extra IF pump current while acquiring
// - RF boost mode from op bit 14 and setup bit 2
// - setup bits 1:0 select lock indicator source
// - bias bit 11 selects low-noise or normal power mode
// - bias bits 6:4 select throttle-back rate
// - bias bits 3:0 scale driver bias current
// - shutdown, idle and transmit-gate pins combine into section enables
// - frame is 24 bits, 20 data msb first then 4 address, rising sclk
// - rising select copies the shift register into the addressed register
// - serial port works and contents stay during any shutdown
module txr_serial_regs (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// three-wire serial port, asynchronous pins
	input wire txr_pkg::txr_serial_t serial_in,
	// power-down pins, active low, asynchronous
	input wire logic power_off_pin_n,
	input wire logic idle_pin_n,
	input wire logic transmit_gate_pin_n,
	// lock detectors from the synthesizers, asynchronous
	input wire logic if_lock_raw,
	input wire logic rf_lock_raw,
	input wire logic test_lock_raw,
	// divider counts and factory test bits
	output logic [17:0] rf_main_count,
	output logic [12:0] rf_reference_count,
	output logic [13:0] if_main_count,
	output logic [10:0] if_reference_count,
	output logic [8:0] factory_test_bits,
	// decoded controls
	output txr_pkg::txr_power_t power_en,
	output logic [2:0] if_gain_trim,
	output logic modulation_select,
	output logic baseband_level_sel,
	output logic [1:0] if_pump_current_sel,
	output logic [1:0] rf_pump_current_sel,
	output logic if_pump_boost,
	output logic rf_pump_boost,
	output logic max_power_level_sel,
	output logic [2:0] throttle_rate_sel,
	output logic [3:0] driver_current_scale,
	output logic lock_out
);
	// synchronisers: pins and lock inputs
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [NSYNC-1:0] pins_raw;
	assign pins_raw = {serial_in.sel_n, serial_in.sclk, serial_in.sdata, power_off_pin_n,
		idle_pin_n, transmit_gate_pin_n, if_lock_raw, rf_lock_raw, test_lock_raw};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync_a <= '1;
			sync_b <= '1;
		end else begin
			sync_a <= pins_raw;
			sync_b <= sync_a;
		end
	end
	logic sel_n_s, sclk_s, sdata_s, off_pin_s, idle_pin_s, gate_pin_s;
	logic if_lock_s, rf_lock_s, test_lock_s;
	assign {sel_n_s, sclk_s, sdata_s, off_pin_s, idle_pin_s, gate_pin_s,
		if_lock_s, rf_lock_s, test_lock_s} = sync_b;

	// edge detect works on the second stage only
	logic sclk_d;
	logic sel_n_d;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_d <= 1'b1;
			sel_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			sel_n_d <= sel_n_s;
		end
	end
	logic sclk_rise;
	logic sel_rise;
	assign sclk_rise = sclk_s && !sclk_d;
	assign sel_rise = sel_n_s && !sel_n_d;

	// shift register, msb first; the last 4 bits in end up as the address
	logic [txr_pkg::FRAME_BITS-1:0] shifter;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			shifter <= '0;
		end else if (!sel_n_s && sclk_rise) begin
			shifter <= {shifter[txr_pkg::FRAME_BITS-2:0], sdata_s};
		end
	end
	logic [txr_pkg::ADDR_BITS-1:0] frame_addr;
	logic [txr_pkg::DATA_BITS-1:0] frame_data;
	assign frame_addr = shifter[txr_pkg::ADDR_BITS-1:0];
	assign frame_data = shifter[txr_pkg::FRAME_BITS-1:txr_pkg::ADDR_BITS];

	// a frame shorter or longer than 24 bits is still latched, as the pin
	// only knows the last 24 bits shifted; no framing check exists
	logic wr_en;
	logic [2:0] wr_idx;
	logic [17:0] wr_data;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_en <= 1'b0;
			wr_idx <= 3'h0;
			wr_data <= 18'h0;
		end else begin
			wr_en <= sel_rise && !frame_addr[txr_pkg::ADDR_TOP];
			wr_idx <= frame_addr[2:0];
			wr_data <= frame_data[17:0];
		end
	end

	logic [8*18-1:0] words;
	txr_reg_mem u_mem (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.rd_all(words)
	);
	logic [17:0] w_rfm, w_rfr, w_ifm, w_ifr, w_op, w_su, w_bi, w_ts;
	assign w_rfm = words[int'(txr_pkg::ADDR_RF_MAIN)*18 +: 18];
	assign w_rfr = words[int'(txr_pkg::ADDR_RF_REF)*18 +: 18];
	assign w_ifm = words[int'(txr_pkg::ADDR_IF_MAIN)*18 +: 18];
	assign w_ifr = words[int'(txr_pkg::ADDR_IF_REF)*18 +: 18];
	assign w_op = words[int'(txr_pkg::ADDR_OPCTL)*18 +: 18];
	assign w_su = words[int'(txr_pkg::ADDR_SETUP)*18 +: 18];
	assign w_bi = words[int'(txr_pkg::ADDR_BIAS)*18 +: 18];
	assign w_ts = words[int'(txr_pkg::ADDR_TEST)*18 +: 18];

	// divider counts and factory test bits, upper bits ignored
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rf_main_count <= '0;
			rf_reference_count <= '0;
			if_main_count <= '0;
			if_reference_count <= '0;
			factory_test_bits <= '0;
		end else begin
			rf_main_count <= w_rfm[txr_pkg::W_RF_MAIN-1:0];
			rf_reference_count <= w_rfr[txr_pkg::W_RF_REF-1:0];
			if_main_count <= w_ifm[txr_pkg::W_IF_MAIN-1:0];
			if_reference_count <= w_ifr[txr_pkg::W_IF_REF-1:0];
			factory_test_bits <= w_ts[txr_pkg::W_TEST-1:0];
		end
	end

	// plain field decodes
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			if_gain_trim <= '0;
			modulation_select <= 1'b0;
			baseband_level_sel <= 1'b0;
			if_pump_current_sel <= '0;
			rf_pump_current_sel <= '0;
			max_power_level_sel <= 1'b0;
			throttle_rate_sel <= '0;
			driver_current_scale <= '0;
		end else begin
			if_gain_trim <= w_op[txr_pkg::OP_GAIN_HI:txr_pkg::OP_GAIN_LO];
			modulation_select <= w_op[txr_pkg::OP_MOD_SEL];
			baseband_level_sel <= w_su[txr_pkg::SU_BB_LEVEL];
			if_pump_current_sel <= w_su[txr_pkg::SU_IFCP_HI:txr_pkg::SU_IFCP_LO];
			rf_pump_current_sel <= w_su[txr_pkg::SU_RFCP_HI:txr_pkg::SU_RFCP_LO];
			max_power_level_sel <= w_bi[txr_pkg::BI_MAX_POWER];
			throttle_rate_sel <= w_bi[txr_pkg::BI_THR_HI:txr_pkg::BI_THR_LO];
			driver_current_scale <= w_bi[txr_pkg::BI_SCALE_HI:txr_pkg::BI_SCALE_LO];
		end
	end

	// power: pins and bits combine; registers and serial port never gated
	logic power_off_ctl, standby_ctl, transmit_standby_ctl, all_off, tx_off;
	assign power_off_ctl = !w_op[txr_pkg::OP_POWER_OFF];
	assign standby_ctl = !w_op[txr_pkg::OP_STANDBY];
	assign transmit_standby_ctl = !w_op[txr_pkg::OP_TX_STANDBY];
	assign all_off = !off_pin_s || power_off_ctl || standby_ctl;
	assign tx_off = all_off || !idle_pin_s || !gate_pin_s || transmit_standby_ctl;
	logic if_off;
	assign if_off = all_off || !idle_pin_s;
	logic if_synth_off_n, rf_synth_off_n;
	assign if_synth_off_n = w_su[txr_pkg::SU_IF_SYNTH];
	assign rf_synth_off_n = w_su[txr_pkg::SU_RF_SYNTH];
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			power_en <= '0;
		end else begin
			power_en.upconverter_on <= !tx_off;
			power_en.modulator_on <= !tx_off;
			power_en.if_osc_on <= !if_off;
			power_en.if_synth_on <= !if_off && if_synth_off_n;
			power_en.rf_synth_on <= !all_off && rf_synth_off_n;
			power_en.lo_buffer_on <= !all_off && w_op[txr_pkg::OP_LO_BUF];
			power_en.bias_on <= !all_off;
		end
	end

	// rf boost: program mode arms on rf divider write, drops once locked
	logic [1:0] boost_mode;
	logic rf_prog_arm;
	assign boost_mode = {w_op[txr_pkg::OP_RF_BOOST_HI], w_su[txr_pkg::SU_RF_BOOST_LO]};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rf_prog_arm <= 1'b0;
		end else if (wr_en && (wr_idx == txr_pkg::ADDR_RF_MAIN[2:0]
				|| wr_idx == txr_pkg::ADDR_RF_REF[2:0])) begin
			rf_prog_arm <= 1'b1;
		end else if (rf_lock_s) begin
			rf_prog_arm <= 1'b0;
		end
	end
	logic next_rf_boost;
	always_comb begin
		case (boost_mode)
			txr_pkg::BOOST_NONE: next_rf_boost = 1'b0;
			txr_pkg::BOOST_PROG: next_rf_boost = rf_prog_arm;
			txr_pkg::BOOST_ALWAYS: next_rf_boost = 1'b1;
			txr_pkg::BOOST_UNLOCK: next_rf_boost = !rf_lock_s;
			default: next_rf_boost = 1'b0;
		endcase
	end
	// if boost: forced on, or turbo while unlocked when enabled
	logic next_if_boost;
	assign next_if_boost = w_op[txr_pkg::OP_IF_FORCE]
		|| (w_su[txr_pkg::SU_IF_TURBO] && !if_lock_s);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rf_pump_boost <= 1'b0;
			if_pump_boost <= 1'b0;
		end else begin
			rf_pump_boost <= next_rf_boost;
			if_pump_boost <= next_if_boost;
		end
	end

	// lock indicator mux
	logic next_lock;
	always_comb begin
		case (w_su[txr_pkg::SU_LOCK_HI:txr_pkg::SU_LOCK_LO])
			txr_pkg::LOCK_TEST: next_lock = test_lock_s;
			txr_pkg::LOCK_IF: next_lock = if_lock_s;
			txr_pkg::LOCK_RF: next_lock = rf_lock_s;
			txr_pkg::LOCK_BOTH: next_lock = if_lock_s && rf_lock_s;
			default: next_lock = 1'b0;
		endcase
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			lock_out <= 1'b0;
		end else begin
			lock_out <= next_lock;
		end
	end

	// checks
	sequence s_frame_latch;
		sel_rise && !frame_addr[txr_pkg::ADDR_TOP];
	endsequence
	bad_addr_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(sel_rise && frame_addr[txr_pkg::ADDR_TOP]) |=> !wr_en)
		else $error("high address frame was written");
	latch_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
		s_frame_latch |=> (wr_en && wr_idx == $past(frame_addr[2:0])))
		else $error("frame not latched on select rise");
	divider_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(wr_en && wr_idx == 3'h0) |-> ##3 (rf_main_count == $past(wr_data, 3)))
		else $error("rf main count not loaded");
	shift_only_low_a: assert property (@(posedge core_clk) disable iff (!nrst)
		sel_n_s |=> $stable(shifter))
		else $error("shifter moved while deselected");
	off_pin_all_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!off_pin_s |=> (power_en == '0))
		else $error("sections on during pin shutdown");
	gate_tx_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!gate_pin_s |=> (!power_en.upconverter_on && !power_en.modulator_on))
		else $error("transmit stayed on under gate");
	if_force_a: assert property (@(posedge core_clk) disable iff (!nrst)
		w_op[txr_pkg::OP_IF_FORCE] |=> if_pump_boost)
		else $error("if pump not forced");
	lock_both_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(w_su[1:0] == txr_pkg::LOCK_BOTH && !rf_lock_s) |=> !lock_out)
		else $error("lock shown without rf lock");
	rf_always_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(boost_mode == txr_pkg::BOOST_ALWAYS) |=> rf_pump_boost)
		else $error("rf boost not always on");
	// a word reaches the view two edges after wr_en, so both edges are left out
	retain_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!off_pin_s && !wr_en && !$past(wr_en)) |=> $stable(w_op))
		else $error("register changed during shutdown");
	shift_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!sel_n_s && sclk_rise) |=>
		(shifter == {$past(shifter[txr_pkg::FRAME_BITS-2:0]), $past(sdata_s)}))
		else $error("shifter did not take one bit");
	standby_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		standby_ctl |=> (power_en == '0))
		else $error("sections on during standby");
	power_bit_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
		power_off_ctl |=> (power_en == '0))
		else $error("sections on with shutdown bit clear");
	tx_standby_a: assert property (@(posedge core_clk) disable iff (!nrst)
		transmit_standby_ctl |=> (!power_en.upconverter_on && !power_en.modulator_on))
		else $error("transmit on with standby bit clear");
	idle_pin_if_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!idle_pin_s |=> (!power_en.if_osc_on && !power_en.if_synth_on))
		else $error("if sections on while idle");
	if_synth_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!if_synth_off_n |=> !power_en.if_synth_on)
		else $error("if synthesizer on while shut down");
	rf_synth_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
		!rf_synth_off_n |=> !power_en.rf_synth_on)
		else $error("rf synthesizer on while shut down");
	rf_none_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(boost_mode == txr_pkg::BOOST_NONE) |=> !rf_pump_boost)
		else $error("rf boost on in no-boost mode");
	rf_unlock_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(boost_mode == txr_pkg::BOOST_UNLOCK) |=> (rf_pump_boost == !$past(rf_lock_s)))
		else $error("rf boost does not follow unlock");
	sequence s_rf_reprog;
		wr_en && (wr_idx == txr_pkg::ADDR_RF_MAIN[2:0]
			|| wr_idx == txr_pkg::ADDR_RF_REF[2:0]);
	endsequence
	prog_arm_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
		s_rf_reprog |=> rf_prog_arm)
		else $error("rf reprogramming did not arm boost");
	prog_arm_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(rf_lock_s && !wr_en) |=> !rf_prog_arm)
		else $error("rf boost stayed armed after lock");
	prog_boost_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(boost_mode == txr_pkg::BOOST_PROG && rf_prog_arm) |=> rf_pump_boost)
		else $error("armed rf boost not applied");
	if_turbo_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(w_su[txr_pkg::SU_IF_TURBO] && !if_lock_s) |=> if_pump_boost)
		else $error("if turbo missing while acquiring");
	if_normal_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!w_op[txr_pkg::OP_IF_FORCE] && !w_su[txr_pkg::SU_IF_TURBO]) |=> !if_pump_boost)
		else $error("if boost on with turbo disabled");
endmodule : txr_serial_regs

// *** tb/txr_host_model.sv ***
`timescale 1ns/1ps
// host side of the three-wire port, paced from core_clk falling edges
module txr_host_model (
	// clock
	input wire logic core_clk,
	// serial pins
	output txr_pkg::txr_serial_t serial
);
	localparam int HALF = 8; // 80 ns, half of the 160 ns link clock
	initial begin
		serial = 3'h4;
	end
	// reserved fields always go out at their normal values
	function automatic logic [19:0] fix_rsv(input logic [3:0] a, input logic [19:0] d);
		logic [19:0] r;
		r = d;
		if (a == 4'h4) begin
			r[15:5] = {1'b0, d[14:13], 4'h4, d[8:6], 1'b0};
		end
		if (a == 4'h5) begin
			r[13] = 1'b0;
			r[11:10] = 2'h0;
			r[5:4] = 2'h3;
		end
		if (a == 4'h6) begin
			r[15:12] = 4'h0;
			r[10:7] = 4'h8;
		end
		return r;
	endfunction : fix_rsv
	task automatic send(input logic [3:0] a, input logic [19:0] d);
		logic [23:0] f;
		f = {fix_rsv(a, d), a};
		@(negedge core_clk);
		serial.sel_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			serial.sdata = f[i];
			repeat (HALF) @(negedge core_clk);
			serial.sclk = 1'b1;
			repeat (HALF) @(negedge core_clk);
			serial.sclk = 1'b0;
		end
		serial.sel_n = 1'b1;
		// released data line must not keep showing the last bit
		serial.sdata = ~f[0];
		repeat (HALF) @(negedge core_clk);
	endtask : send
endmodule : txr_host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	txr_pkg::txr_serial_t serial_in;
	logic power_off_pin_n = 1'b1, idle_pin_n = 1'b1, transmit_gate_pin_n = 1'b1;
	logic if_lock_raw = 1'b0, rf_lock_raw = 1'b0, test_lock_raw = 1'b0;
	logic [17:0] rf_main_count;
	logic [12:0] rf_reference_count;
	logic [13:0] if_main_count;
	logic [10:0] if_reference_count;
	logic [8:0] factory_test_bits;
	txr_pkg::txr_power_t power_en;
	logic [2:0] if_gain_trim, throttle_rate_sel;
	logic [1:0] if_pump_current_sel, rf_pump_current_sel;
	logic [3:0] driver_current_scale;
	logic modulation_select, baseband_level_sel, if_pump_boost, rf_pump_boost;
	logic max_power_level_sel, lock_out;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	wire [3:0] pw = {power_en.upconverter_on, power_en.modulator_on,
		power_en.if_synth_on, power_en.rf_synth_on};
	always #5 core_clk = ~core_clk;
	txr_host_model u_txr_host_model (.core_clk, .serial(serial_in));
	txr_serial_regs u_txr_serial_regs (.core_clk, .nrst, .serial_in, .power_off_pin_n,
		.idle_pin_n, .transmit_gate_pin_n, .if_lock_raw, .rf_lock_raw, .test_lock_raw,
		.rf_main_count, .rf_reference_count, .if_main_count, .if_reference_count,
		.factory_test_bits, .power_en, .if_gain_trim, .modulation_select,
		.baseband_level_sel, .if_pump_current_sel, .rf_pump_current_sel, .if_pump_boost,
		.rf_pump_boost, .max_power_level_sel, .throttle_rate_sel, .driver_current_scale,
		.lock_out);
	task automatic complete_run();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// leaves room for sync and output register latency after select rises
	task automatic wr(input logic [3:0] a, input logic [19:0] d);
		u_txr_host_model.send(a, d);
		repeat (12) @(negedge core_clk);
	endtask : wr
	task automatic pins(input logic [2:0] v);
		@(negedge core_clk);
		{power_off_pin_n, idle_pin_n, transmit_gate_pin_n} = v;
		repeat (6) @(negedge core_clk);
	endtask : pins
	task automatic lk(input logic [1:0] v);
		@(negedge core_clk);
		{if_lock_raw, rf_lock_raw} = v;
		repeat (6) @(negedge core_clk);
	endtask : lk
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(negedge core_clk);
		nrst = 1'b1;
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 4; i++) wr(4'(i), 20'hfffff);
		chk("rf_main", 32'h3ffff, rf_main_count);
		chk("rf_ref", 32'h1fff, rf_reference_count);
		chk("if_main", 32'h3fff, if_main_count);
		chk("if_ref", 32'h7ff, if_reference_count);
		wr(4'h7, 20'hfffff);
		chk("test_bits", 32'h1ff, factory_test_bits);
		wr(4'h8, 20'h00000);
		wr(4'hf, 20'h00000);
		chk("rf_main", 32'h3ffff, rf_main_count);
		chk("test_bits", 32'h1ff, factory_test_bits);
		wr(4'h0, 20'h6a5c3);
		chk("rf_main", 32'h2a5c3, rf_main_count);
		for (int k = 0; k < 2; k++) begin
			wr(4'h5, k ? 20'h0c182 : 20'h0d241);
			wr(4'h4, k ? 20'h00087 : 20'h0014f);
			wr(4'h6, k ? 20'h00013 : 20'h0086c);
			chk("bb_level", k ? 32'h0 : 32'h1, baseband_level_sel);
			chk("if_pump", k ? 32'h1 : 32'h2, if_pump_current_sel);
			chk("rf_pump", k ? 32'h2 : 32'h1, rf_pump_current_sel);
			chk("gain", k ? 32'h2 : 32'h5, if_gain_trim);
			chk("mod_sel", k ? 32'h0 : 32'h1, modulation_select);
			chk("max_pwr", k ? 32'h0 : 32'h1, max_power_level_sel);
			chk("throttle", k ? 32'h1 : 32'h6, throttle_rate_sel);
			chk("scale", k ? 32'h3 : 32'hc, driver_current_scale);
			chk("power_en", 32'hf, pw);
		end
		wr(4'h4, 20'h00085);
		chk("power_en", 32'h3, pw);
		chk("power_all", 32'h1d, power_en);
		wr(4'h4, 20'h00083);
		chk("power_en", 32'h0, pw);
		wr(4'h4, 20'h00086);
		chk("power_en", 32'h0, pw);
		wr(4'h4, 20'h00097);
		chk("power_all", 32'h7f, power_en);
		wr(4'h5, 20'h04182);
		chk("power_en", 32'hd, pw);
		wr(4'h5, 20'h08182);
		chk("power_en", 32'he, pw);
		wr(4'h5, 20'h0c182);
		pins(3'h3);
		chk("power_en", 32'h0, pw);
		chk("power_all", 32'h00, power_en);
		// port must still accept frames while the pin holds everything down
		wr(4'h1, 20'h00abc);
		chk("rf_ref", 32'h0abc, rf_reference_count);
		pins(3'h5);
		chk("power_en", 32'h1, pw);
		chk("power_all", 32'h07, power_en);
		pins(3'h6);
		chk("power_en", 32'h3, pw);
		chk("power_all", 32'h1f, power_en);
		pins(3'h7);
		chk("power_en", 32'hf, pw);
		chk("power_all", 32'h7f, power_en);
		for (int c = 0; c < 4; c++) begin
			wr(4'h5, 20'h0c180 | 20'(c));
			for (int p = 0; p < 8; p++) begin
				@(negedge core_clk);
				{if_lock_raw, rf_lock_raw, test_lock_raw} = 3'(p);
				repeat (6) @(negedge core_clk);
				chk("lock_out", c == 0 ? p[0] : c == 1 ? p[2] : c == 2 ? p[1] : p[2] & p[1],
					lock_out);
			end
		end
		lk(2'h0);
		wr(4'h5, 20'h0c183);
		chk("rf_boost", 32'h0, rf_pump_boost);
		wr(4'h4, 20'h04087);
		lk(2'h3);
		chk("rf_boost", 32'h1, rf_pump_boost);
		wr(4'h5, 20'h0c187);
		chk("rf_boost", 32'h0, rf_pump_boost);
		lk(2'h0);
		chk("rf_boost", 32'h1, rf_pump_boost);
		wr(4'h4, 20'h00087);
		chk("rf_boost", 32'h0, rf_pump_boost);
		wr(4'h0, 20'h05000);
		chk("rf_boost", 32'h1, rf_pump_boost);
		lk(2'h1);
		chk("rf_boost", 32'h0, rf_pump_boost);
		lk(2'h0);
		chk("rf_boost", 32'h0, rf_pump_boost);
		wr(4'h4, 20'h02087);
		lk(2'h2);
		chk("if_boost", 32'h1, if_pump_boost);
		wr(4'h4, 20'h00087);
		wr(4'h5, 20'h0c18b);
		chk("if_boost", 32'h0, if_pump_boost);
		lk(2'h0);
		chk("if_boost", 32'h1, if_pump_boost);
		wr(4'h5, 20'h0c183);
		chk("if_boost", 32'h0, if_pump_boost);
		complete_run();
	end
endmodule : tb
